/* File: core/pin_control_pkg.sv */
// Package with the register map and reset values of the eight-pin control block
package pin_control_pkg;
  // ==========================================================
  // Register map
  localparam int unsigned PIN_COUNT = 8;
  localparam logic [11:0] PIN_CONTROL_OFFSET = 12'h0B8;
  localparam logic [11:0] PORT_STATUS_OFFSET = 12'h0BC;
  // ==========================================================
  // Field positions inside each four-bit pin group
  localparam int unsigned GROUP_WIDTH = 4;
  localparam int unsigned INPUT_POS = 0;
  localparam int unsigned DIR_POS = 1;
  localparam int unsigned VALUE_POS = 2;
  localparam int unsigned RESERVED_POS = 3;
  // ==========================================================
  // Reset values
  localparam logic INPUT_RESET = 1'h1;
  localparam logic DIR_RESET = 1'h0;
  localparam logic VALUE_RESET = 1'h0;
  localparam int unsigned SYNC_STAGES = 2;
endpackage

/* File: core/pin_sync.sv */
// Two-stage synchroniser for one pin level, with a settable reset value
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic level_o
);
  logic meta_ff;
  logic level_ff;
  logic nxt_meta;
  logic nxt_level;

  always_comb begin
    nxt_meta = pin_i;
    nxt_level = meta_ff;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_ff <= RESET_VALUE;
      level_ff <= RESET_VALUE;
    end else begin
      meta_ff <= nxt_meta;
      level_ff <= nxt_level;
    end
  end

  assign level_o = level_ff;
endmodule
`default_nettype wire

/* File: core/pin_control.sv */
// Eight-pin general-purpose control register behind an APB slave
// How it works
// RULE_01 - The register exists only when the port is the upstream port, at offset B8h.
// RULE_02 - Each input bit is read-only, shows the synchronised pin level and reads one after reset.
// RULE_03 - Each direction bit is writable, zero means input and one output, reset to zero.
// RULE_04 - A pin set as output is driven with its writable output value bit, reset to zero.
// RULE_05 - Pin zero's output value is used only while downstream port one's PME feature is off.
// RULE_06 - Pin one's output value is used only while downstream port two's PME feature is off.
// RULE_07 - Pin n uses bits 4n input, 4n+1 direction, 4n+2 value and 4n+3 reserved.
// RULE_08 - A pin set as input is not driven, and reserved bits read zero and ignore writes.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pin_control
  import pin_control_pkg::*;
#(
  parameter int unsigned PINS = pin_control_pkg::PIN_COUNT
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic upstream_port_i,
  input wire logic pme_port1_enable_i,
  input wire logic pme_port2_enable_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [PINS-1:0] pin_in_i,
  output logic [PINS-1:0] pin_out_o,
  output logic [PINS-1:0] pin_oe_o
);
  import pin_control_pkg::*;

  // ==========================================================
  // Pin input synchronisers
  logic [PINS-1:0] pin_level;
  logic [2:0] sel_sync_ff;
  logic [2:0] nxt_sel_sync;
  logic [2:0] cfg_sync_ff;
  logic [2:0] nxt_cfg_sync;
  logic is_upstream;
  logic pme1_on;
  logic pme2_on;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_sync
      pin_sync #(
        .RESET_VALUE(INPUT_RESET)
      ) u_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(pin_in_i[gi]),
        .level_o(pin_level[gi])
      );
    end
  endgenerate

  // Strap and PME enables arrive from other logic but are treated as async levels
  always_comb begin
    nxt_sel_sync = {pme_port2_enable_i, pme_port1_enable_i, upstream_port_i};
    nxt_cfg_sync = sel_sync_ff;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sel_sync_ff <= 3'h0;
      cfg_sync_ff <= 3'h0;
    end else begin
      sel_sync_ff <= nxt_sel_sync;
      cfg_sync_ff <= nxt_cfg_sync;
    end
  end

  assign is_upstream = cfg_sync_ff[0];
  assign pme1_on = cfg_sync_ff[1];
  assign pme2_on = cfg_sync_ff[2];

  // ==========================================================
  // Control bits
  logic [PINS-1:0] dir_ff;
  logic [PINS-1:0] value_ff;
  logic [PINS-1:0] nxt_dir;
  logic [PINS-1:0] nxt_value;
  logic access;
  logic hit_ctrl;
  logic hit_status;
  logic wr_ctrl;
  logic [31:0] ctrl_word;

  // A write is taken in its access cycle, read data is captured in the setup cycle; pready is always high
  assign access = psel_i && penable_i;
  assign hit_ctrl = (paddr_i == PIN_CONTROL_OFFSET) && is_upstream; // RULE_01
  assign hit_status = (paddr_i == PORT_STATUS_OFFSET) && is_upstream;
  assign wr_ctrl = access && pwrite_i && hit_ctrl;

  // Each byte lane holds two pin groups
  always_comb begin
    nxt_dir = dir_ff;
    nxt_value = value_ff;
    if (wr_ctrl) begin
      for (int i = 0; i < PINS; i++) begin
        if (pstrb_i[(i * GROUP_WIDTH) / 8]) begin
          nxt_dir[i] = pwdata_i[i * GROUP_WIDTH + DIR_POS]; // RULE_03 RULE_07
          nxt_value[i] = pwdata_i[i * GROUP_WIDTH + VALUE_POS]; // RULE_04 RULE_07
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      dir_ff <= {PINS{DIR_RESET}};
      value_ff <= {PINS{VALUE_RESET}};
    end else begin
      dir_ff <= nxt_dir;
      value_ff <= nxt_value;
    end
  end

  // ==========================================================
  // Register image
  always_comb begin
    ctrl_word = 32'h0000_0000; // RULE_08
    for (int i = 0; i < PINS; i++) begin
      ctrl_word[i * GROUP_WIDTH + INPUT_POS] = pin_level[i]; // RULE_02 RULE_07
      ctrl_word[i * GROUP_WIDTH + DIR_POS] = dir_ff[i];
      ctrl_word[i * GROUP_WIDTH + VALUE_POS] = value_ff[i];
    end
  end

  // ==========================================================
  // Pin drivers
  logic [PINS-1:0] out_ff;
  logic [PINS-1:0] oe_ff;
  logic [PINS-1:0] nxt_out;
  logic [PINS-1:0] nxt_oe;

  always_comb begin
    nxt_oe = dir_ff; // RULE_03 RULE_08
    nxt_out = value_ff & dir_ff; // RULE_04
    // While a PME feature owns the pin, the software value is not used
    if (pme1_on) begin
      nxt_out[0] = 1'b0; // RULE_05
      nxt_oe[0] = 1'b0; // RULE_05
    end
    if (pme2_on && PINS > 1) begin
      nxt_out[1] = 1'b0; // RULE_06
      nxt_oe[1] = 1'b0; // RULE_06
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      out_ff <= '0;
      oe_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      oe_ff <= nxt_oe;
    end
  end

  assign pin_out_o = out_ff;
  assign pin_oe_o = oe_ff;

  // ==========================================================
  // APB read data and error
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel_i && !penable_i && !pwrite_i) begin
      if (hit_ctrl) begin
        nxt_rdata = ctrl_word;
      end else if (hit_status) begin
        nxt_rdata = {29'h0, pme2_on, pme1_on, is_upstream};
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata_o = rdata_ff;
  assign pready_o = 1'b1;
  // Unmapped addresses, downstream ports and writes to the status word answer with an error
  assign pslverr_o = access && !(hit_ctrl || (hit_status && !pwrite_i)); // RULE_01
endmodule
`default_nettype wire

/* File: verif/pin_board.sv */
// Board model: each pin shows the block's drive or the board's own level
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_o
);
  assign pin_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule
`default_nettype wire

/* File: verif/pin_control_chk.sv */
// Port checks for the pin control block
`timescale 1ns/1ps
`default_nettype none
module pin_control_chk #(
  parameter int unsigned PINS = 8
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic pme_port1_enable_i,
  input wire logic pme_port2_enable_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [PINS-1:0] pin_out_o,
  input wire logic [PINS-1:0] pin_oe_o
);
  logic acc;
  assign acc = psel_i && penable_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_high: assert property (pready_o) else $error("not ready");
  a_bad_addr: assert property (acc && paddr_i != 12'h0B8 && (paddr_i != 12'h0BC || pwrite_i)
    |-> pslverr_o) else $error("bad address taken");
  a_dir_write: assert property (acc && pwrite_i && pstrb_i[1] && !pslverr_o
    |-> ##2 pin_oe_o[3:2] == {$past(pwdata_i[13], 2), $past(pwdata_i[9], 2)})
    else $error("dir lost");
  a_val_write: assert property (acc && pwrite_i && pstrb_i[2] && pwdata_i[17] && !pslverr_o
    |-> ##2 pin_out_o[4] == $past(pwdata_i[18], 2)) else $error("value lost");
  a_rsvd_zero: assert property (acc && !pwrite_i |-> (prdata_o & 32'h88888888) == 0)
    else $error("reserved set");
  a_err_zero: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 0)
    else $error("refused read data");
  a_oe_hold: assert property (!(acc && pwrite_i) && !$past(acc && pwrite_i)
    |=> $stable(pin_oe_o[PINS-1:2]))
    else $error("enable moved");
  a_pme1_off: assert property (pme_port1_enable_i [*5] |-> !pin_oe_o[0])
    else $error("pin 0 driven");
  a_pme2_off: assert property (pme_port2_enable_i [*5] |-> !pin_oe_o[1])
    else $error("pin 1 driven");
  c_write: cover property (acc && pwrite_i && !pslverr_o);
  c_read: cover property (acc && !pwrite_i && !pslverr_o);
  c_err: cover property (acc && pslverr_o);
endmodule
bind pin_control pin_control_chk #(.PINS(PINS)) u_pin_control_chk (.*);
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the pin control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pin_control_pkg::*;
  logic clock_i, rst_b_i, upstream_port_i, pme_port1_enable_i, pme_port2_enable_i;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, r, m, d;
  logic [3:0] pstrb_i, s;
  logic [7:0] pin_in_i, pin_out_o, pin_oe_o, ext;
  int err_count, n_tests;
  pin_control u_pin_control (.*);
  pin_board u_pin_board (.out_i(pin_out_o), .oe_i(pin_oe_o), .ext_i(ext), .pin_o(pin_in_i));
  function automatic logic [31:0] word(input logic [31:0] w, input logic [7:0] x);
    word = w & 32'h66666666;
    for (int n = 0; n < 8; n++) word[4*n] = w[4*n+1] ? w[4*n+2] : x[n];
  endfunction
  function automatic logic [7:0] fld(input logic [31:0] w, input int p);
    for (int n = 0; n < 8; n++) fld[n] = w[4*n+p];
  endfunction
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    n_tests++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
    int n;
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    pstrb_i <= b;
    @(posedge clock_i);
    penable_i <= 1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) err_count++;
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clock_i);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    err_count++;
    give_verdict;
  end
  initial begin
    void'($urandom(76924));
    {rst_b_i, upstream_port_i, pme_port1_enable_i, pme_port2_enable_i} = 0;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = 0;
    ext = 8'hFF;
    m = 0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1;
    upstream_port_i <= 1;
    repeat (4) @(posedge clock_i);
    chk(pin_oe_o, 0);
    apb(0, 12'h0B8, 0, 4'hF); chk({e, r}, 33'h011111111);
    for (int i = 0; i < 30; i++) begin
      d = $urandom;
      s = (i < 4) ? 4'h1 << i : 4'($urandom);
      ext <= 8'($urandom);
      apb(1, 12'h0B8, d, s);
      for (int k = 0; k < 4; k++) if (s[k]) m[8*k+:8] = d[8*k+:8];
      repeat (3) @(posedge clock_i);
      apb(0, 12'h0B8, 0, 4'hF); chk({e, r}, word(m, ext));
      chk(pin_oe_o, fld(m, 1));
      chk(pin_out_o, fld(m, 2) & fld(m, 1));
    end
    pme_port1_enable_i <= 1;
    pme_port2_enable_i <= 1;
    ext <= 8'hFF;
    m = 32'h66666666;
    apb(1, 12'h0B8, m, 4'hF);
    repeat (5) @(posedge clock_i);
    chk(pin_oe_o, 8'hFC);
    chk(pin_out_o, 8'hFC);
    apb(0, 12'h0BC, 0, 4'hF); chk({e, r}, 33'h000000007);
    apb(1, 12'h0BC, 0, 4'hF); chk(e, 1);
    apb(0, 12'h0B8, 0, 4'hF); chk({e, r}, word(m, ext));
    apb(0, 12'h0C0, 0, 4'hF); chk({e, r}, 33'h100000000);
    apb(1, 12'h0B4, 0, 4'hF); chk(e, 1);
    upstream_port_i <= 0;
    repeat (3) @(posedge clock_i);
    apb(1, 12'h0B8, 0, 4'hF);
    apb(0, 12'h0B8, 0, 4'hF); chk({e, r}, 33'h100000000);
    upstream_port_i <= 1;
    repeat (3) @(posedge clock_i);
    apb(0, 12'h0B8, 0, 4'hF); chk({e, r}, word(m, ext));
    give_verdict;
  end
endmodule
`default_nettype wire
